// >>> core/dbpm_pin_mux.sv
// external bus pin mode select, host port front end and serial port one pin mux
`timescale 1ns/1ps
`default_nettype none
module dbpm_pin_mux
	import dbpm_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_mode_strap,
	input wire logic i_bus_request_in_n,
	input wire logic i_emu_bus_request_in_n,
	input wire logic [ADDR_W-1:0] i_core_addr,
	input wire logic [DATA_W-1:0] i_core_data_out,
	input wire logic i_core_data_drive,
	input wire logic i_core_byte_access,
	input wire logic [BYTE_HI_W-1:0] i_core_byte_addr_hi,
	input wire logic i_core_pm_sel,
	input wire logic i_core_dm_sel,
	input wire logic i_core_io_sel,
	input wire logic i_core_ovl_sel,
	output logic [DATA_W-1:0] o_core_data_in,
	output logic o_host_mode,
	output logic [ADDR_W-1:0] o_ext_address_out,
	output logic [ADDR_W-1:0] o_ext_address_oe_n,
	input wire logic [DATA_W-1:0] i_ext_data_bus,
	output logic [DATA_W-1:0] o_ext_data_bus,
	output logic [DATA_W-1:0] o_ext_data_bus_oe_n,
	output logic o_program_mem_select_n,
	output logic o_data_mem_select_n,
	output logic o_io_space_select_n,
	output logic o_overlay_mem_select_n,
	output logic o_mem_select_oe_n,
	input wire logic [HBUS_W-1:0] i_host_addr_data_bus,
	output logic [HBUS_W-1:0] o_host_addr_data_bus,
	output logic o_host_addr_data_bus_oe_n,
	input wire logic i_host_write_strobe_n,
	input wire logic i_host_read_strobe_n,
	input wire logic i_host_addr_latch,
	input wire logic i_host_port_select_n,
	output logic o_host_port_ack_n,
	output logic [HBUS_W-1:0] o_hdma_addr,
	output logic [HBUS_W-1:0] o_hdma_wdata,
	output logic o_hdma_wr,
	output logic o_hdma_rd,
	input wire logic [HBUS_W-1:0] i_hdma_rdata,
	input wire logic i_sp1_alt_en,
	input wire logic i_sp_rfs_out,
	input wire logic i_sp_rfs_drive,
	input wire logic i_sp_tfs_out,
	input wire logic i_sp_tfs_drive,
	input wire logic i_sp_dt,
	input wire logic i_sp_sclk_out,
	input wire logic i_sp_sclk_internal,
	input wire logic i_flag_out,
	output logic o_sp_rfs_in,
	output logic o_sp_tfs_in,
	output logic o_sp_dr,
	output logic o_sp_sclk_in,
	output logic o_alt_irq_zero_n,
	output logic o_alt_irq_one_n,
	output logic o_flag_in,
	input wire logic i_sp1_rfs,
	output logic o_sp1_rfs,
	output logic o_sp1_rfs_oe_n,
	input wire logic i_sp1_tfs,
	output logic o_sp1_tfs,
	output logic o_sp1_tfs_oe_n,
	input wire logic i_sp1_dr,
	output logic o_sp1_dt,
	input wire logic i_sp1_sclk,
	output logic o_sp1_sclk,
	output logic o_sp1_sclk_oe_n
);
	typedef struct packed {
		logic [2:0] settle;
		logic mode;
		dbpm_hp_state_t hp;
		logic [1:0] busy;
		logic [HBUS_W-1:0] hdma_addr;
		logic [HBUS_W-1:0] hdma_wdata;
		logic [HBUS_W-1:0] hbus_out;
		logic hbus_drive;
		logic hdma_wr;
		logic hdma_rd;
		logic ack_n;
		logic wr_prev;
		logic rd_prev;
		logic al_prev;
		logic [ADDR_W-1:0] addr_out;
		logic [ADDR_W-1:0] addr_oe_n;
		logic [DATA_W-1:0] data_out;
		logic [DATA_W-1:0] data_oe_n;
		logic [DATA_W-1:0] data_in;
		logic [3:0] sel_n;
		logic sel_oe_n;
		logic rfs_out;
		logic rfs_oe_n;
		logic tfs_out;
		logic tfs_oe_n;
		logic dt_out;
		logic sclk_out;
		logic sclk_oe_n;
		logic alt_irq_zero_n;
		logic alt_irq_one_n;
		logic flag_in;
		logic run;
	} dbpm_state_t;

	dbpm_state_t q;
	dbpm_state_t d;
	logic [SY_W-1:0] sy_in;
	logic [SY_W-1:0] sy;
	logic strap_s;
	logic [HBUS_W-1:0] sy_hbus;
	logic bus_float;
	logic sel_ok;

	// every pin input is synchronised before use
	assign sy_in = {i_sp1_sclk, i_sp1_dr, i_sp1_tfs, i_sp1_rfs, i_emu_bus_request_in_n,
		i_bus_request_in_n, i_host_port_select_n, i_host_addr_latch, i_host_read_strobe_n,
		i_host_write_strobe_n, i_host_addr_data_bus, i_ext_data_bus};

	dbpm_sync3 #(.W(SY_W), .RST_VAL(SY_RST)) u_pin_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_async(sy_in),
		.o_sync(sy)
	);

	// strap chain keeps running in reset so the level can be caught there
	dbpm_sync3 #(.W(1), .RST_VAL(1'h0)) u_strap_sync (
		.i_clk(i_clk),
		.i_rst_n(1'b1),
		.i_async(i_mode_strap),
		.o_sync(strap_s)
	);

	assign sy_hbus = sy[SY_HBUS +: HBUS_W];
	assign bus_float = ~sy[SY_BR] | ~sy[SY_EBR];
	assign sel_ok = ~sy[SY_SEL];

	// next state; synchronous reset is folded in here
	always_comb begin
		d = q;
		// run is low on the edge that leaves reset, so checks skip that edge
		d.run = 1'b1;
		// settle counts reset cycles only; clearing it here makes each reset recount
		d.settle = 3'h0;
		d.hdma_wr = 1'b0;
		d.hdma_rd = 1'b0;
		d.wr_prev = sy[SY_WR];
		d.rd_prev = sy[SY_RD];
		d.al_prev = sy[SY_AL];
		if (q.busy != 2'h0) begin
			d.busy = q.busy - 2'h1;
		end
		// host port sequencer, live only in host mode
		case (q.hp)
			DBPM_HP_IDLE: begin
				if (q.mode == MODE_HOST && sel_ok) begin
					if (sy[SY_AL] && !q.al_prev) begin
						d.hdma_addr = sy_hbus;
					end else if (q.wr_prev && !sy[SY_WR]) begin
						d.hdma_wr = 1'b1;
						d.hdma_wdata = sy_hbus;
						d.hp = DBPM_HP_WR;
						d.busy = ACK_BUSY;
					end else if (q.rd_prev && !sy[SY_RD]) begin
						d.hdma_rd = 1'b1;
						d.hp = DBPM_HP_RD;
						d.busy = ACK_BUSY;
					end
				end
			end
			DBPM_HP_WR: begin
				if (sy[SY_WR] || !sel_ok) begin
					d.hp = DBPM_HP_IDLE;
					d.hdma_addr = q.hdma_addr + 16'h1;
				end
			end
			DBPM_HP_RD: begin
				d.hbus_out = i_hdma_rdata;
				d.hbus_drive = 1'b1;
				if (sy[SY_RD] || !sel_ok) begin
					d.hp = DBPM_HP_IDLE;
					d.hbus_drive = 1'b0;
					d.hdma_addr = q.hdma_addr + 16'h1;
				end
			end
			default: begin
				d.hp = DBPM_HP_IDLE;
				d.hbus_drive = 1'b0;
			end
		endcase
		d.ack_n = ~(q.mode == MODE_HOST && sel_ok && d.hp == DBPM_HP_IDLE && d.busy == 2'h0);
		// external memory bus; roles never change after reset
		d.addr_out = i_core_addr;
		d.addr_oe_n = '0;
		d.data_out = i_core_data_out;
		d.data_oe_n = i_core_data_drive ? '0 : '1;
		d.data_in = sy[SY_DATA +: DATA_W];
		if (q.mode == MODE_FULL && i_core_byte_access) begin
			d.data_out[BYTE_HI_LSB +: BYTE_HI_W] = i_core_byte_addr_hi;
			d.data_oe_n[BYTE_HI_LSB +: BYTE_HI_W] = '0;
		end
		if (q.mode == MODE_HOST) begin
			// only the low address bit and data 23..8 remain
			d.addr_out[ADDR_W-1:1] = '0;
			d.addr_oe_n[ADDR_W-1:1] = '1;
			d.data_out[HOST_DATA_LSB-1:0] = '0;
			d.data_oe_n[HOST_DATA_LSB-1:0] = '1;
			d.data_in[HOST_DATA_LSB-1:0] = '0;
		end
		// selects stay out unless a bus request floats them, so outside logic can decode peripherals
		d.sel_n = ~{i_core_ovl_sel, i_core_io_sel, i_core_dm_sel, i_core_pm_sel};
		d.sel_oe_n = bus_float;
		if (bus_float) begin
			d.addr_oe_n = '1;
			d.data_oe_n = '1;
		end
		// serial port one frame and data pins follow software while i_sp1_alt_en is low
		d.rfs_out = i_sp_rfs_out;
		d.rfs_oe_n = ~i_sp_rfs_drive;
		d.tfs_out = i_sp_tfs_out;
		d.tfs_oe_n = ~i_sp_tfs_drive;
		d.dt_out = i_sp_dt;
		d.alt_irq_zero_n = 1'b1;
		d.alt_irq_one_n = 1'b1;
		if (i_sp1_alt_en) begin
			d.rfs_oe_n = 1'b1;
			d.tfs_oe_n = 1'b1;
			d.dt_out = i_flag_out;
			d.alt_irq_zero_n = sy[SY_RFS];
			d.alt_irq_one_n = sy[SY_TFS];
		end
		// flag input always tracks, so both roles live together
		d.flag_in = sy[SY_DR];
		// internal clock is independent of the alternate pin use
		d.sclk_out = i_sp_sclk_out;
		d.sclk_oe_n = ~i_sp_sclk_internal;
		if (!i_rst_n) begin
			d = '0;
			d.hp = DBPM_HP_IDLE;
			d.ack_n = 1'b1;
			d.wr_prev = 1'b1;
			d.rd_prev = 1'b1;
			d.addr_oe_n = '1;
			d.data_oe_n = '1;
			d.sel_n = '1;
			d.sel_oe_n = 1'b1;
			d.rfs_oe_n = 1'b1;
			d.tfs_oe_n = 1'b1;
			d.sclk_oe_n = 1'b1;
			d.alt_irq_zero_n = 1'b1;
			d.alt_irq_one_n = 1'b1;
			// strap trusted only once its chain has filled
			d.settle = (q.settle == STRAP_SETTLE) ? STRAP_SETTLE : q.settle + 3'h1;
			d.mode = (q.settle == STRAP_SETTLE) ? strap_s : MODE_FULL;
		end
	end

	// mode is only written in the reset branch above
	always_ff @(posedge i_clk) begin
		q <= d;
	end

	assign o_host_mode = q.mode;
	assign o_core_data_in = q.data_in;
	assign o_ext_address_out = q.addr_out;
	assign o_ext_address_oe_n = q.addr_oe_n;
	assign o_ext_data_bus = q.data_out;
	assign o_ext_data_bus_oe_n = q.data_oe_n;
	assign {o_overlay_mem_select_n, o_io_space_select_n, o_data_mem_select_n,
		o_program_mem_select_n} = q.sel_n;
	assign o_mem_select_oe_n = q.sel_oe_n;
	assign o_host_addr_data_bus = q.hbus_out;
	assign o_host_addr_data_bus_oe_n = ~q.hbus_drive;
	assign o_host_port_ack_n = q.ack_n;
	assign o_hdma_addr = q.hdma_addr;
	assign o_hdma_wdata = q.hdma_wdata;
	assign o_hdma_wr = q.hdma_wr;
	assign o_hdma_rd = q.hdma_rd;
	assign o_sp_rfs_in = sy[SY_RFS];
	assign o_sp_tfs_in = sy[SY_TFS];
	assign o_sp_dr = sy[SY_DR];
	assign o_sp_sclk_in = sy[SY_SCLK];
	assign o_alt_irq_zero_n = q.alt_irq_zero_n;
	assign o_alt_irq_one_n = q.alt_irq_one_n;
	assign o_flag_in = q.flag_in;
	assign o_sp1_rfs = q.rfs_out;
	assign o_sp1_rfs_oe_n = q.rfs_oe_n;
	assign o_sp1_tfs = q.tfs_out;
	assign o_sp1_tfs_oe_n = q.tfs_oe_n;
	assign o_sp1_dt = q.dt_out;
	assign o_sp1_sclk = q.sclk_out;
	assign o_sp1_sclk_oe_n = q.sclk_oe_n;

	// checks run only outside reset
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n || !q.run);

	mode_hold_a: assert property ($stable(q.mode))
		else $error("mode changed while running");
	full_addr_a: assert property ((q.mode == MODE_FULL && !bus_float) |=>
		(o_ext_address_oe_n == '0 && o_ext_address_out == $past(i_core_addr)))
		else $error("full mode address not driven");
	host_pins_a: assert property ((q.mode == MODE_HOST) |=>
		(o_ext_address_oe_n[ADDR_W-1:1] == '1 && o_ext_data_bus_oe_n[HOST_DATA_LSB-1:0] == '1))
		else $error("host mode drives full mode pins");
	host_write_a: assert property ((q.mode == MODE_HOST && q.hp == DBPM_HP_IDLE &&
		sel_ok && !(sy[SY_AL] && !q.al_prev) && q.wr_prev && !sy[SY_WR]) |=>
		(o_hdma_wr && o_hdma_wdata == $past(sy_hbus) && o_host_port_ack_n))
		else $error("host write not taken");
	byte_addr_a: assert property ((q.mode == MODE_FULL && i_core_byte_access &&
		!bus_float) |=>
		(o_ext_data_bus[BYTE_HI_LSB +: BYTE_HI_W] == $past(i_core_byte_addr_hi) &&
		o_ext_data_bus_oe_n[BYTE_HI_LSB +: BYTE_HI_W] == '0))
		else $error("byte address missing on upper data");
	sp_switch_a: assert property ($fell(i_sp1_alt_en) |=>
		(o_sp1_rfs_oe_n == $past(~i_sp_rfs_drive) && o_sp1_dt == $past(i_sp_dt)))
		else $error("serial pins did not switch back");
	shared_roles_a: assert property (i_sp1_alt_en |=>
		(o_alt_irq_zero_n == $past(sy[SY_RFS]) && o_flag_in == $past(sy[SY_DR])))
		else $error("flag and interrupt not both live");
	alt_pins_a: assert property (i_sp1_alt_en |=> (o_sp1_rfs_oe_n && o_sp1_tfs_oe_n &&
		o_alt_irq_one_n == $past(sy[SY_TFS]) && o_sp1_dt == $past(i_flag_out)))
		else $error("alternate serial pins wrong");
	sclk_alt_a: assert property ((i_sp1_alt_en && i_sp_sclk_internal) |=>
		(!o_sp1_sclk_oe_n && o_sp1_sclk == $past(i_sp_sclk_out)))
		else $error("internal serial clock lost");
	idle_ignore_a: assert property (!sel_ok |=>
		(!o_hdma_wr && !o_hdma_rd && o_host_port_ack_n))
		else $error("deselected host port acted");

	full_byte_c: cover property (q.mode == MODE_FULL && i_core_byte_access && !bus_float);
	host_wr_c: cover property (q.hp == DBPM_HP_WR ##1 q.hp == DBPM_HP_IDLE);
	host_rd_c: cover property (o_hdma_rd ##[1:20] !o_host_addr_data_bus_oe_n);
	alt_switch_c: cover property ($rose(i_sp1_alt_en) ##[1:50] $fell(i_sp1_alt_en));
endmodule : dbpm_pin_mux
`default_nettype wire

// >>> core/dbpm_pkg.sv
// constants and types shared by the bus pin mode select block
`default_nettype none
package dbpm_pkg;
	localparam int ADDR_W = 14;
	localparam int DATA_W = 24;
	localparam int HBUS_W = 16;
	localparam int BYTE_HI_W = 8;
	localparam int BYTE_HI_LSB = 16;
	localparam int HOST_DATA_LSB = 8;
	// operating modes chosen by the strap
	localparam logic MODE_FULL = 1'h0;
	localparam logic MODE_HOST = 1'h1;
	// reset cycles before the synchronised strap is trusted
	localparam logic [2:0] STRAP_SETTLE = 3'h4;
	// acknowledge stays inactive this many cycles after an access starts
	localparam logic [1:0] ACK_BUSY = 2'h2;
	// positions in the synchronised pin vector
	localparam int SY_DATA = 0;
	localparam int SY_HBUS = 24;
	localparam int SY_WR = 40;
	localparam int SY_RD = 41;
	localparam int SY_AL = 42;
	localparam int SY_SEL = 43;
	localparam int SY_BR = 44;
	localparam int SY_EBR = 45;
	localparam int SY_RFS = 46;
	localparam int SY_TFS = 47;
	localparam int SY_DR = 48;
	localparam int SY_SCLK = 49;
	localparam int SY_W = 50;
	// strobes and bus requests reset to their inactive levels
	localparam logic [SY_W-1:0] SY_RST = 50'h3B0000000000;
	typedef enum logic [2:0] {
		DBPM_HP_IDLE = 3'h1,
		DBPM_HP_WR = 3'h2,
		DBPM_HP_RD = 3'h4
	} dbpm_hp_state_t;
endpackage : dbpm_pkg
`default_nettype wire

// >>> core/dbpm_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module dbpm_sync3
	import dbpm_pkg::*;
#(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] val;
	} dbpm_sync_t;

	dbpm_sync_t q;
	dbpm_sync_t d;

	// s1 feeds only s2; val moves once s2 and s3 agree
	always_comb begin
		d = q;
		d.s1 = i_async;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.val = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.val);
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
		end else begin
			q <= d;
		end
	end

	assign o_sync = q.val;
endmodule : dbpm_sync3
`default_nettype wire

// >>> test/dbpm_host_model.sv
// host processor model that drives the multiplexed host port strobes
`timescale 1ns/1ps
`default_nettype none
module dbpm_host_model
	import dbpm_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_ack_n,
	input wire logic [HBUS_W-1:0] i_bus,
	output logic [HBUS_W-1:0] o_bus,
	output logic o_wr_n,
	output logic o_rd_n,
	output logic o_al,
	output logic o_sel_n
);
	// idle host: strobes inactive, not selected
	initial begin
		o_bus = 16'h0000;
		o_wr_n = 1'b1;
		o_rd_n = 1'b1;
		o_al = 1'b0;
		o_sel_n = 1'b1;
	end
	// one access: k 0 latch, 1 write, 2 read; strobe held long enough to clear the filter
	task automatic xfer(input int k, input logic s, input logic [15:0] v,
		output logic [15:0] r);
		o_bus <= v;
		o_sel_n <= s;
		o_al <= (k == 0);
		o_wr_n <= (k != 1);
		o_rd_n <= (k != 2);
		repeat (10) @(posedge i_clk);
		r = i_bus;
		o_al <= 1'b0;
		o_wr_n <= 1'b1;
		o_rd_n <= 1'b1;
		o_bus <= ~v; // released bus must not look like the last word
		// one edge passes so a following call never re-drives a strobe in this step
		@(posedge i_clk);
		for (int n = 0; n < 20 && i_ack_n !== 1'b0; n++) @(posedge i_clk);
	endtask : xfer
endmodule : dbpm_host_model
`default_nettype wire

// >>> test/dbpm_pin_mux_tb_top.sv
// self-checking bench for the bus pin mode select block
`timescale 1ns/1ps
`default_nettype none
module dbpm_pin_mux_tb_top;
	import dbpm_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_mode_strap = 1'b0;
	logic [16:0] ci = 17'h00003;
	logic [13:0] ca = '0;
	logic [23:0] cd = '0;
	logic [7:0] cb = '0;
	logic [23:0] ed = 24'h000000;
	logic [15:0] hr = '0;
	logic [3:0] pin = '0;
	logic [7:0] wr_cnt = '0;
	logic [7:0] rd_cnt = '0;
	logic o_hdma_rd, o_sp_rfs_in, o_sp_tfs_in, o_sp_dr, o_sp_sclk_in;
	logic [15:0] wr_a, wr_d, h_bus;
	logic h_wr_n, h_rd_n, h_al, h_sel_n;
	logic [23:0] o_core_data_in, i_ext_data_bus, o_ext_data_bus, o_ext_data_bus_oe_n;
	logic [13:0] o_ext_address_out, o_ext_address_oe_n;
	logic [15:0] i_host_addr_data_bus, o_host_addr_data_bus, o_hdma_addr, o_hdma_wdata;
	logic o_host_mode, o_mem_select_oe_n, o_host_addr_data_bus_oe_n, o_host_port_ack_n;
	logic o_hdma_wr, o_alt_irq_zero_n, o_alt_irq_one_n, o_flag_in, i_sp1_rfs, o_sp1_rfs;
	logic o_sp1_rfs_oe_n, i_sp1_tfs, o_sp1_tfs, o_sp1_tfs_oe_n, o_sp1_dt, i_sp1_sclk;
	logic o_sp1_sclk, o_sp1_sclk_oe_n;
	wire [3:0] sel_n;
	int miscompares = 0;
	int total_checks = 0;
	// wire levels from every party's enables
	assign i_ext_data_bus = (o_ext_data_bus & ~o_ext_data_bus_oe_n) | (ed & o_ext_data_bus_oe_n);
	assign i_host_addr_data_bus = o_host_addr_data_bus_oe_n ? h_bus : o_host_addr_data_bus;
	assign i_sp1_rfs = o_sp1_rfs_oe_n ? pin[0] : o_sp1_rfs;
	assign i_sp1_tfs = o_sp1_tfs_oe_n ? pin[1] : o_sp1_tfs;
	assign i_sp1_sclk = o_sp1_sclk_oe_n ? pin[3] : o_sp1_sclk;
	always #25 i_clk = ~i_clk;
	dbpm_pin_mux u_dbpm_pin_mux (
		.i_clk, .i_rst_n, .i_mode_strap,
		.i_bus_request_in_n(ci[0]), .i_emu_bus_request_in_n(ci[1]),
		.i_core_addr(ca), .i_core_data_out(cd), .i_core_data_drive(ci[2]),
		.i_core_byte_access(ci[3]), .i_core_byte_addr_hi(cb),
		.i_core_pm_sel(ci[4]), .i_core_dm_sel(ci[5]), .i_core_io_sel(ci[6]),
		.i_core_ovl_sel(ci[7]), .o_core_data_in, .o_host_mode,
		.o_ext_address_out, .o_ext_address_oe_n, .i_ext_data_bus,
		.o_ext_data_bus, .o_ext_data_bus_oe_n,
		.o_program_mem_select_n(sel_n[0]), .o_data_mem_select_n(sel_n[1]),
		.o_io_space_select_n(sel_n[2]), .o_overlay_mem_select_n(sel_n[3]),
		.o_mem_select_oe_n, .i_host_addr_data_bus, .o_host_addr_data_bus,
		.o_host_addr_data_bus_oe_n, .i_host_write_strobe_n(h_wr_n),
		.i_host_read_strobe_n(h_rd_n), .i_host_addr_latch(h_al),
		.i_host_port_select_n(h_sel_n), .o_host_port_ack_n, .o_hdma_addr,
		.o_hdma_wdata, .o_hdma_wr, .o_hdma_rd, .i_hdma_rdata(hr),
		.i_sp1_alt_en(ci[8]), .i_sp_rfs_out(ci[9]), .i_sp_rfs_drive(ci[10]),
		.i_sp_tfs_out(ci[11]), .i_sp_tfs_drive(ci[12]), .i_sp_dt(ci[13]),
		.i_sp_sclk_out(ci[14]), .i_sp_sclk_internal(ci[15]), .i_flag_out(ci[16]),
		.o_sp_rfs_in, .o_sp_tfs_in, .o_sp_dr, .o_sp_sclk_in,
		.o_alt_irq_zero_n, .o_alt_irq_one_n, .o_flag_in,
		.i_sp1_rfs, .o_sp1_rfs, .o_sp1_rfs_oe_n, .i_sp1_tfs, .o_sp1_tfs,
		.o_sp1_tfs_oe_n, .i_sp1_dr(pin[2]), .o_sp1_dt, .i_sp1_sclk, .o_sp1_sclk,
		.o_sp1_sclk_oe_n
	);
	dbpm_host_model u_dbpm_host_model (
		.i_clk, .i_ack_n(o_host_port_ack_n), .i_bus(i_host_addr_data_bus),
		.o_bus(h_bus), .o_wr_n(h_wr_n), .o_rd_n(h_rd_n), .o_al(h_al), .o_sel_n(h_sel_n)
	);
	// capture each write pulse towards the memory side
	always @(posedge i_clk) begin
		if (o_hdma_wr === 1'b1) begin
			wr_cnt <= wr_cnt + 8'h01;
			wr_a <= o_hdma_addr;
			wr_d <= o_hdma_wdata;
		end
		if (o_hdma_rd === 1'b1) begin
			rd_cnt <= rd_cnt + 8'h01;
		end
	end
	task automatic chk(input logic [23:0] s, input logic [23:0] e);
		total_checks++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic w(input int n);
		repeat (n) @(posedge i_clk);
	endtask : w
	// held past the strap settle count so the latched mode is trusted
	task automatic rst();
		i_rst_n <= 1'b0;
		w(8);
		i_rst_n <= 1'b1;
		w(2);
	endtask : rst
	task automatic t_full();
		chk(o_host_mode, MODE_FULL);
		ca <= 14'h2A5C;
		cd <= 24'hC3A581;
		ci[2] <= 1'b1;
		ci[4] <= 1'b1;
		w(3);
		chk(o_ext_address_out, 14'h2A5C);
		chk(o_ext_address_oe_n, 14'h0000);
		chk(o_ext_data_bus, 24'hC3A581);
		chk(sel_n, 4'hE);
		ci[3] <= 1'b1;
		cb <= 8'hD7;
		w(3);
		chk(o_ext_data_bus, 24'hD7A581);
		ci[2] <= 1'b0;
		ci[3] <= 1'b0;
		ed <= 24'h5A0F3C;
		w(8);
		chk(o_ext_data_bus_oe_n, 24'hFFFFFF);
		chk(o_core_data_in, 24'h5A0F3C);
		ci[1] <= 1'b0;
		w(8);
		chk(o_ext_address_oe_n, 14'h3FFF);
		chk(o_mem_select_oe_n, 1'b1);
		ci[1] <= 1'b1;
		i_mode_strap <= 1'b1;
		w(8);
		chk(o_host_mode, MODE_FULL);
		chk(o_ext_address_oe_n, 14'h0000);
	endtask : t_full
	task automatic t_host();
		logic [15:0] r;
		chk(o_host_mode, MODE_HOST);
		chk(o_ext_address_oe_n, 14'h3FFE);
		chk(o_ext_data_bus_oe_n[7:0], 8'hFF);
		u_dbpm_host_model.xfer(0, 1'b0, 16'h1234, r);
		u_dbpm_host_model.xfer(1, 1'b0, 16'hBEEF, r);
		chk(wr_cnt, 8'h01);
		chk(wr_a, 16'h1234);
		chk(wr_d, 16'hBEEF);
		chk(o_host_port_ack_n, 1'b0);
		u_dbpm_host_model.xfer(1, 1'b0, 16'h0F0F, r);
		chk(wr_a, 16'h1235);
		hr <= 16'h8C31;
		u_dbpm_host_model.xfer(2, 1'b0, 16'h0000, r);
		chk(r, 16'h8C31);
		chk(rd_cnt, 8'h01);
		u_dbpm_host_model.xfer(1, 1'b1, 16'h7777, r);
		chk(wr_cnt, 8'h02);
	endtask : t_host
	task automatic t_serial();
		ci[16] <= 1'b1;
		w(8);
		chk(o_sp1_dt, 1'b0);
		chk(o_alt_irq_zero_n, 1'b1);
		ci[8] <= 1'b1;
		ci[15] <= 1'b1;
		pin <= 4'b0110;
		w(8);
		chk(o_sp1_rfs_oe_n, 1'b1);
		chk(o_sp1_tfs_oe_n, 1'b1);
		chk(o_sp1_dt, 1'b1);
		chk(o_alt_irq_zero_n, 1'b0);
		chk(o_alt_irq_one_n, 1'b1);
		chk(o_flag_in, 1'b1);
		chk(o_sp1_sclk_oe_n, 1'b0);
		chk({o_sp_sclk_in, o_sp_dr, o_sp_tfs_in, o_sp_rfs_in}, 4'h6);
		ci[8] <= 1'b0;
		ci[10] <= 1'b1;
		w(3);
		chk(o_sp1_rfs_oe_n, 1'b0);
		chk(o_alt_irq_zero_n, 1'b1);
	endtask : t_serial
	task automatic close_out();
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out
	// main sequence: full mode, then host mode after a second reset
	initial begin
		w(1);
		rst();
		t_full();
		rst();
		t_host();
		t_serial();
		close_out();
	end
	// watchdog well beyond the few hundred cycles the tests need
	initial begin
		#1000000;
		miscompares++;
		close_out();
	end
endmodule : dbpm_pin_mux_tb_top
`default_nettype wire
